// ===== rtl/scl_pkg.sv
package scl_pkg;

  // ==========================================
  // register command codes
  localparam logic [7:0] REG_FW_STATUS = 8'h41;
  localparam logic [7:0] REG_LOAD_CTRL = 8'h60;
  localparam logic [7:0] REG_DATA_PORT = 8'h61;
  localparam logic [7:0] REG_START_LO = 8'h62;
  localparam logic [7:0] REG_START_HI = 8'h63;

  // ==========================================
  // code_load_control fields
  localparam int CTL_HOST_LOAD_SEL = 7;
  localparam int CTL_CPU_HOLD = 6;
  localparam int CTL_PARITY_CHECK = 4;
  localparam int CTL_RUN_FROM_RAM = 3;
  localparam int CTL_PARITY_SEL = 2;
  localparam int CTL_READ_NOT_WRITE = 1;
  localparam int CTL_POINTER_CLEAR = 0;

  // ==========================================
  // reset and status values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] START_RESET = 8'h00;
  localparam logic [7:0] FW_STATUS_RESET = 8'h00;
  localparam logic [7:0] FW_INVALID = 8'hff;
  localparam logic [7:0] FW_VALID_MIN = 8'h01;
  localparam logic [7:0] FW_VALID_MAX = 8'hfe;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ==========================================
  // two-wire bus addressing
  localparam logic [6:0] GLOBAL_ADDR = 7'h7f;
  localparam logic [1:0] ADDR_PREFIX = 2'h2;
  localparam logic [3:0] ACK_POS = 4'h8;
  localparam logic [3:0] LAST_DATA_POS = 4'h7;
  localparam logic [3:0] LAST_ADDR_POS = 4'h6;

  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CHECK_TIME_NS = 1000000;
  localparam int CHECK_CYCLES = CHECK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_CMD, BUS_WDATA, BUS_RDATA, BUS_IGNORE
  } scl_bus_state_t;

endpackage

// ===== rtl/scl_code_loader.sv
`timescale 1ns/1ps
// Operation
// - sixteen-bit start address in two registers
// - loading through the lower address, not the upper
// - global broadcast address also loads
// - reload accepted while in safe mode
// - data port bytes stored from start
// - parity select routes bytes to parity
// - compatibility check finishes within limit
// - valid load gives status one to fe
// - invalid load: status ff, ram off unless a host write sets run-from-ram in the same cycle
// - pointer clear resets, release frees pointer
// - data port bursts until stop condition
// - processor hold touches no register
// - run-from-ram selects ram plus rom
module scl_code_loader #(
  parameter int MEM_AW = 10,
  // arbitrary firmware code reported on a good load
  parameter logic [7:0] FW_VALID_CODE = 8'h01,
  parameter int CHECK_CYCLES = scl_pkg::CHECK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [3:0] addrStrap,
  output logic cpuHold,
  output logic runFromRam,
  output logic parityCheckOn,
  output logic checkBusy,
  output logic safeMode
);
  localparam int DEPTH = 1 << MEM_AW;
  if (MEM_AW < 1 || MEM_AW > 16 || DEPTH + 2 > CHECK_CYCLES ||
      FW_VALID_CODE < scl_pkg::FW_VALID_MIN ||
      FW_VALID_CODE > scl_pkg::FW_VALID_MAX) begin : g_bad_param
    $error("scl_code_loader: unsupported parameter values");
  end
  // ==========================================
  // link domain: sample on rising scl, drive on falling scl
  logic linkBit_r;
  logic linkTgl_r;
  logic sdaOe_r;
  logic [1:0] slot0_r;
  logic [1:0] slot1_r;
  wire [1:0] slotSel = linkTgl_r ? slot1_r : slot0_r;
  always_ff @(posedge sclClk or negedge reset_n) begin
    if (!reset_n) begin
      linkBit_r <= 1'b0;
      linkTgl_r <= 1'b0;
    end else begin
      linkBit_r <= sdaIn;
      linkTgl_r <= ~linkTgl_r;
    end
  end
  // the slot read here was written a full bit earlier, so it is stable;
  // a master nack releases the line without waiting for the core clock
  always_ff @(negedge sclClk or negedge reset_n) begin
    if (!reset_n) begin
      sdaOe_r <= 1'b0;
    end else begin
      sdaOe_r <= slotSel[0] & ~(slotSel[1] & linkBit_r);
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_r;
  // ==========================================
  // synchronisers into the core clock
  logic sclS1, sclS2;
  logic sdaS1, sdaS2, sdaS3;
  logic tglS1, tglS2, tglS3;
  logic [3:0] strapS1, strapS2;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {sclS1, sclS2} <= 2'h3;
      {sdaS1, sdaS2, sdaS3} <= 3'h7;
      {tglS1, tglS2, tglS3} <= 3'h0;
      strapS1 <= 4'h0;
      strapS2 <= 4'h0;
    end else begin
      {sclS1, sclS2} <= {sclClk, sclS1};
      {sdaS1, sdaS2, sdaS3} <= {sdaIn, sdaS1, sdaS2};
      {tglS1, tglS2, tglS3} <= {linkTgl_r, tglS1, tglS2};
      strapS1 <= addrStrap;
      strapS2 <= strapS1;
    end
  end
  wire startEv = sclS2 & sdaS3 & ~sdaS2;
  wire stopEv = sclS2 & ~sdaS3 & sdaS2;
  wire bitEv = tglS2 ^ tglS3;
  // linkBit_r holds for a whole scl period after its toggle moves
  wire bitIn = linkBit_r;
  // ==========================================
  // byte framing
  scl_pkg::scl_bus_state_t state_r;
  logic [3:0] pos_r;
  logic [6:0] rx_r;
  logic [7:0] tx_r;
  logic [7:0] regPtr_r;
  logic selected_r;
  logic loadAcc_r;
  logic [7:0] ctrl_r;
  logic [7:0] startLo_r;
  logic [7:0] startHi_r;
  logic [7:0] fwStatus_r;
  logic [15:0] ptr_r;
  wire [7:0] byteIn = {rx_r, bitIn};
  wire [6:0] addrNow = {rx_r[5:0], bitIn};
  wire [6:0] lowerAddr = {scl_pkg::ADDR_PREFIX, strapS2, 1'b0};
  wire [6:0] upperAddr = {scl_pkg::ADDR_PREFIX, strapS2, 1'b1};
  wire hitLoad = (addrNow == lowerAddr) ||
                 (addrNow == scl_pkg::GLOBAL_ADDR);
  wire hitAny = hitLoad || (addrNow == upperAddr);
  wire inAddr = state_r == scl_pkg::BUS_ADDR;
  wire inRead = state_r == scl_pkg::BUS_RDATA;
  wire inWrite = (state_r == scl_pkg::BUS_CMD) ||
                 (state_r == scl_pkg::BUS_WDATA);
  wire atLast = pos_r == scl_pkg::LAST_DATA_POS;
  wire atAck = pos_r == scl_pkg::ACK_POS;
  wire atAddrEnd = pos_r == scl_pkg::LAST_ADDR_POS;
  wire progSel = ctrl_r[scl_pkg::CTL_HOST_LOAD_SEL];
  wire parSel = ctrl_r[scl_pkg::CTL_PARITY_SEL];
  wire rnwSel = ctrl_r[scl_pkg::CTL_READ_NOT_WRITE];
  wire ptrClr = ctrl_r[scl_pkg::CTL_POINTER_CLEAR];
  wire onPort = regPtr_r == scl_pkg::REG_DATA_PORT;
  wire portRead = onPort && loadAcc_r && progSel && rnwSel && !ptrClr;
  wire portWrite = onPort && loadAcc_r && progSel && !rnwSel && !ptrClr;
  // ==========================================
  // program and parity memories
  logic [7:0] progMem [DEPTH];
  logic [7:0] parMem [DEPTH];
  wire [15:0] ptrNext = 16'(ptr_r + 16'h1);
  wire [15:0] rdAddr = inRead ? ptrNext : ptr_r;
  wire [MEM_AW-1:0] rdIdx = rdAddr[MEM_AW-1:0];
  wire [MEM_AW-1:0] wrIdx = ptr_r[MEM_AW-1:0];
  wire [7:0] memRd = parSel ? parMem[rdIdx] : progMem[rdIdx];
  wire [7:0] regRdVal =
    !loadAcc_r ? scl_pkg::READ_IDLE :
    (regPtr_r == scl_pkg::REG_FW_STATUS) ? fwStatus_r :
    (regPtr_r == scl_pkg::REG_LOAD_CTRL) ? ctrl_r :
    (regPtr_r == scl_pkg::REG_DATA_PORT) ?
      (portRead ? memRd : scl_pkg::READ_IDLE) :
    (regPtr_r == scl_pkg::REG_START_LO) ? startLo_r :
    (regPtr_r == scl_pkg::REG_START_HI) ? startHi_r :
    scl_pkg::READ_IDLE;
  // ==========================================
  // drive decision two bits ahead of the line
  wire readStart = inAddr && atLast && selected_r && bitIn;
  wire [7:0] txUse = atLast ? regRdVal : tx_r;
  wire readUse = atLast ? (readStart || inRead) : inRead;
  wire nackNow = inRead && atAck && bitIn;
  wire ackUse = inAddr ? hitAny : inWrite;
  wire [3:0] tgtPos = atLast ? 4'h0 : atAck ? 4'h1 : 4'(pos_r + 4'h2);
  wire [2:0] txBit = 3'(4'h7 - tgtPos);
  wire slotDrive = atAddrEnd ? ackUse :
                   (readUse && !nackNow && !txUse[txBit]);
  wire slotGate = readUse && (tgtPos == 4'h0);
  wire [1:0] slotVal = {slotGate, slotDrive};
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slot0_r <= 2'h0;
      slot1_r <= 2'h0;
    end else if (startEv || stopEv) begin
      slot0_r <= 2'h0;
      slot1_r <= 2'h0;
    end else if (bitEv && tglS2) begin
      slot0_r <= slotVal;
    end else if (bitEv) begin
      slot1_r <= slotVal;
    end
  end
  // ==========================================
  // bus state machine
  wire byteDone = bitEv && atLast;
  scl_pkg::scl_bus_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      scl_pkg::BUS_IDLE, scl_pkg::BUS_IGNORE: ;
      scl_pkg::BUS_ADDR: begin
        if (byteDone) begin
          state_nxt = !selected_r ? scl_pkg::BUS_IGNORE :
                      bitIn ? scl_pkg::BUS_RDATA : scl_pkg::BUS_CMD;
        end
      end
      scl_pkg::BUS_CMD: begin
        if (byteDone) begin
          state_nxt = scl_pkg::BUS_WDATA;
        end
      end
      scl_pkg::BUS_WDATA: ;
      scl_pkg::BUS_RDATA: begin
        if (bitEv && nackNow) begin
          state_nxt = scl_pkg::BUS_IGNORE;
        end
      end
    endcase
    if (startEv) begin
      state_nxt = scl_pkg::BUS_ADDR;
    end else if (stopEv) begin
      state_nxt = scl_pkg::BUS_IDLE;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= scl_pkg::BUS_IDLE;
      pos_r <= 4'h0;
      rx_r <= 7'h00;
    end else begin
      state_r <= state_nxt;
      if (startEv) begin
        pos_r <= 4'h0;
      end else if (bitEv) begin
        pos_r <= atAck ? 4'h0 : 4'(pos_r + 4'h1);
        rx_r <= addrNow;
      end
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      selected_r <= 1'b0;
      loadAcc_r <= 1'b0;
      regPtr_r <= 8'h00;
      tx_r <= 8'h00;
    end else if (bitEv) begin
      if (inAddr && atAddrEnd) begin
        selected_r <= hitAny;
        loadAcc_r <= hitLoad;
      end
      if (state_r == scl_pkg::BUS_CMD && atLast) begin
        regPtr_r <= byteIn;
      end
      if (atLast && (readStart || inRead)) begin
        tx_r <= regRdVal;
      end
    end
  end
  // ==========================================
  // register writes and data port
  wire wrByte = byteDone && state_r == scl_pkg::BUS_WDATA && loadAcc_r;
  wire wrCtrl = wrByte && regPtr_r == scl_pkg::REG_LOAD_CTRL;
  wire wrPort = wrByte && portWrite;
  wire rdPort = byteDone && inRead && portRead;
  // the run sequence is complete when ram is newly enabled with the
  // host released and the processor let go
  wire runSeqDone = wrCtrl && byteIn[scl_pkg::CTL_RUN_FROM_RAM] &&
                    !byteIn[scl_pkg::CTL_HOST_LOAD_SEL] &&
                    !byteIn[scl_pkg::CTL_CPU_HOLD] &&
                    !ctrl_r[scl_pkg::CTL_RUN_FROM_RAM];
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      startLo_r <= scl_pkg::START_RESET;
      startHi_r <= scl_pkg::START_RESET;
    end else if (wrByte && regPtr_r == scl_pkg::REG_START_LO) begin
      startLo_r <= byteIn;
    end else if (wrByte && regPtr_r == scl_pkg::REG_START_HI) begin
      startHi_r <= byteIn;
    end
  end
  // pointer wraps on the memory depth; high start bits are kept for
  // readback only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= 16'h0000;
    end else if (ptrClr) begin
      ptr_r <= {startHi_r, startLo_r};
    end else if (wrPort || rdPort) begin
      ptr_r <= ptrNext;
    end
  end
  always_ff @(posedge mclk) begin
    if (wrPort && parSel) begin
      parMem[wrIdx] <= byteIn;
    end else if (wrPort) begin
      progMem[wrIdx] <= byteIn;
    end
  end
  // ==========================================
  // compatibility check: walk memory comparing parity
  logic chkRun_r;
  logic chkErr_r;
  logic [MEM_AW-1:0] chkIdx_r;
  wire chkLast = chkIdx_r == MEM_AW'(DEPTH - 1);
  wire chkBad = ctrl_r[scl_pkg::CTL_PARITY_CHECK] &&
                ((^progMem[chkIdx_r]) != parMem[chkIdx_r][0]);
  wire chkErrNow = chkErr_r || chkBad;
  wire chkDone = chkRun_r && chkLast;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chkRun_r <= 1'b0;
      chkErr_r <= 1'b0;
      chkIdx_r <= '0;
    end else if (runSeqDone) begin
      chkRun_r <= 1'b1;
      chkErr_r <= 1'b0;
      chkIdx_r <= '0;
    end else if (chkRun_r) begin
      chkRun_r <= !chkLast;
      chkErr_r <= chkErrNow;
      chkIdx_r <= MEM_AW'(chkIdx_r + 1'b1);
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fwStatus_r <= scl_pkg::FW_STATUS_RESET;
    end else if (chkDone) begin
      fwStatus_r <= chkErrNow ? scl_pkg::FW_INVALID
                              : FW_VALID_CODE;
    end
  end
  // a host write in the same cycle takes precedence over the drop to rom
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= scl_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_r <= byteIn;
    end else if (chkDone && chkErrNow) begin
      ctrl_r[scl_pkg::CTL_RUN_FROM_RAM] <= 1'b0;
    end
  end
  // ==========================================
  // processor-side controls
  assign cpuHold = ctrl_r[scl_pkg::CTL_CPU_HOLD];
  assign runFromRam = ctrl_r[scl_pkg::CTL_RUN_FROM_RAM];
  assign parityCheckOn = ctrl_r[scl_pkg::CTL_PARITY_CHECK];
  assign checkBusy = chkRun_r;
  assign safeMode = fwStatus_r == scl_pkg::FW_INVALID;
endmodule

// ===== testbench/scl_asserts.sv
`timescale 1ns/1ps
// ==========================================
// pin-level checks of the code loader
module scl_asserts #(
  parameter int MEM_AW = 10,
  parameter int CHECK_CYCLES = 100000
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sclClk,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [3:0] addrStrap,
  input wire logic cpuHold,
  input wire logic runFromRam,
  input wire logic parityCheckOn,
  input wire logic checkBusy,
  input wire logic safeMode
);
  localparam int DEPTH = 1 << MEM_AW;
  int busyCnt_r;
  int busyCnt_nxt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // counts cycles of the walk; a delay range would not reach 1 ms
  assign busyCnt_nxt = checkBusy ? busyCnt_r + 1 : 0;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) busyCnt_r <= 0;
    else busyCnt_r <= busyCnt_nxt;
  end
  chk_oe_scl_low: assert property (
    $changed(sdaOe) |-> !sclClk)
    else $error("data line moved while clock high");
  chk_check_cause: assert property (
    $rose(checkBusy) |-> runFromRam && !cpuHold)
    else $error("check began without run request");
  chk_check_length: assert property (
    $fell(checkBusy) |-> busyCnt_r == DEPTH)
    else $error("check walk length wrong");
  chk_check_bound: assert property (
    checkBusy |-> busyCnt_r < CHECK_CYCLES)
    else $error("check overran its time");
  chk_safe_run_off: assert property (
    $rose(safeMode) |-> ##[0:1] !runFromRam)
    else $error("run bit kept in safe mode");
  chk_safe_after_check: assert property (
    $changed(safeMode) |-> $past(checkBusy) || $past(checkBusy, 2))
    else $error("status moved outside a check");
  chk_safe_busy_stable: assert property (
    checkBusy && $past(checkBusy) |-> $stable(safeMode))
    else $error("status moved during a check");
  chk_hold_keeps_status: assert property (
    $changed(cpuHold) |-> $stable(safeMode))
    else $error("processor hold changed status");
  chk_drive_low_only: assert property (
    sdaOe |-> !sdaOut)
    else $error("data line driven high");
  cover property ($fell(checkBusy));
  cover property ($rose(safeMode));
  cover property ($fell(safeMode));
  cover property ($rose(cpuHold));
endmodule

bind scl_code_loader scl_asserts #(
  .MEM_AW(MEM_AW), .CHECK_CYCLES(CHECK_CYCLES)
) i_scl_asserts (
  .mclk(mclk), .reset_n(reset_n), .sclClk(sclClk), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrap(addrStrap),
  .cpuHold(cpuHold), .runFromRam(runFromRam),
  .parityCheckOn(parityCheckOn), .checkBusy(checkBusy),
  .safeMode(safeMode)
);

// ===== testbench/scl_host.sv
`timescale 1ns/1ps
// ==========================================
// two-wire bus host, 48 ns bit period, clock idles high
module scl_host (
  input wire logic mclk,
  input wire logic sdaOe,
  output logic scl,
  output logic sda
);
  logic pullLow;
  // pulled-up line: whoever pulls low wins
  assign sda = !(pullLow || sdaOe);
  initial begin
    scl = 1'b1;
    pullLow = 1'b0;
  end
  task automatic bitIo(input logic b, output logic got);
    #12 pullLow = !b;
    #12 scl = 1'b1;
    #12 got = sda;
    #12 scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic last,
    output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
    bitIo(last, ack);
  endtask
  // start held 24 ns so the core clock sees it in sync
  task automatic go(input logic [7:0] a);
    logic [7:0] rx;
    logic ack;
    #12 pullLow = 1'b0;
    #12 scl = 1'b1;
    #12 pullLow = 1'b1;
    #24 scl = 1'b0;
    xfer(a, 1'b1, rx, ack);
  endtask
  task automatic stop();
    #12 pullLow = 1'b1;
    #12 scl = 1'b1;
    #12 pullLow = 1'b0;
  endtask
  // half-cycle plus 2.5 ns offset keeps wire edges off the core clock edge
  task automatic wr(input logic [6:0] a, input logic [7:0] r,
    input logic [7:0] q [$]);
    logic [7:0] rx;
    logic ack;
    @(negedge mclk);
    #2.5;
    go({a, 1'b0});
    xfer(r, 1'b1, rx, ack);
    foreach (q[i]) xfer(q[i], 1'b1, rx, ack);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] r,
    input int n, output logic [7:0] q [$]);
    logic [7:0] rx;
    logic ack;
    q = {};
    @(negedge mclk);
    #2.5;
    go({a, 1'b0});
    xfer(r, 1'b1, rx, ack);
    go({a, 1'b1});
    for (int i = 0; i < n; i++) begin
      xfer(8'hff, i == n - 1, rx, ack);
      q.push_back(rx);
    end
    stop();
  endtask
endmodule

// ===== testbench/tb_scl_code_loader.sv
`timescale 1ns/1ps
module tb_scl_code_loader;
  localparam int AW = 4;
  localparam int N = 1 << AW;
  localparam logic [7:0] VCODE = 8'h5a; // arbitrary firmware code
  logic mclk, reset_n, sclClk, sdaIn, sdaOe, cpuHold, runFromRam;
  logic parityCheckOn, checkBusy, safeMode;
  logic [3:0] addrStrap;
  int miscompares, testsRun;
  logic [16:0] seed;
  logic [6:0] lo, hi;
  logic [15:0] sa;
  logic [7:0] q [$];
  logic [7:0] pq [$];
  logic [7:0] dq [$];
  logic [7:0] regs [4] = '{8'h60, 8'h62, 8'h63, 8'h41};
  scl_code_loader #(.MEM_AW(AW), .FW_VALID_CODE(VCODE),
    .CHECK_CYCLES(N + 4)) i_scl_code_loader (
    .mclk(mclk), .reset_n(reset_n), .sclClk(sclClk), .sdaIn(sdaIn),
    .sdaOut(), .sdaOe(sdaOe), .addrStrap(addrStrap), .cpuHold(cpuHold),
    .runFromRam(runFromRam), .parityCheckOn(parityCheckOn),
    .checkBusy(checkBusy), .safeMode(safeMode));
  scl_host i_scl_host (.mclk(mclk), .sdaOe(sdaOe), .scl(sclClk),
    .sda(sdaIn));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #400000;
    $display("Error at %0t: timeout", $time);
    miscompares++;
    report_and_stop();
  end
  // ==========================================
  // expectations and comparisons
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  // bit 0 is the parity of the code byte; upper bits are filler
  function automatic logic [7:0] parOf(input logic [7:0] b,
    input logic [6:0] r);
    return {r, ^b};
  endfunction
  task automatic chkB(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chkF(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: flag %b, want %b", $time, got, exp);
    end
  endtask
  task automatic rdCmp(input logic [7:0] r, input logic [7:0] e [$]);
    i_scl_host.rd(lo, r, e.size(), q);
    foreach (e[i]) chkB(q[i], e[i]);
  endtask
  // one list serves both directions: the read bit rides in m
  task automatic setup(input logic [6:0] a, input logic [7:0] m);
    i_scl_host.wr(a, 8'h60, {m | 8'h02, m, m | 8'h01, m});
  endtask
  task automatic runCheck(input logic [7:0] st, input logic [7:0] ctl);
    i_scl_host.wr(lo, 8'h60, {8'h18});
    for (int i = 0; i < 40 && checkBusy !== 1'b0; i++) @(negedge mclk);
    chkF(checkBusy, 1'b0);
    rdCmp(8'h41, {st});
    rdCmp(8'h60, {ctl});
    chkF(runFromRam, ctl[3]);
    chkF(parityCheckOn, ctl[4]);
    chkF(safeMode, st == 8'hff);
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================
  // main sequence; loading traffic plus two upper-address probes until done
  initial begin
    reset_n = 1'b0;
    addrStrap = 4'h0;
    miscompares = 0;
    testsRun = 0;
    seed = 17'h10f96;
    @(negedge mclk);
    seed = lfsr(seed);
    addrStrap = seed[3:0];
    lo = {scl_pkg::ADDR_PREFIX, addrStrap, 1'b0};
    hi = {scl_pkg::ADDR_PREFIX, addrStrap, 1'b1};
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    chkF(safeMode, 1'b0);
    foreach (regs[i]) rdCmp(regs[i], {8'h00});
    seed = lfsr(seed);
    sa = seed[15:0];
    i_scl_host.wr(lo, 8'h62, {sa[7:0]});
    i_scl_host.wr(lo, 8'h63, {sa[15:8]});
    i_scl_host.wr(hi, 8'h62, {~sa[7:0]});
    rdCmp(8'h62, {sa[7:0]});
    rdCmp(8'h63, {sa[15:8]});
    i_scl_host.rd(hi, 8'h62, 1, q);
    chkB(q[0], 8'h00);
    for (int i = 0; i < N; i++) begin
      seed = lfsr(seed);
      dq.push_back(seed[7:0]);
      pq.push_back(parOf(seed[7:0], seed[14:8]));
    end
    setup(7'h7f, 8'hc0);
    chkF(cpuHold, 1'b1);
    i_scl_host.wr(7'h7f, 8'h61, dq);
    setup(lo, 8'hc4);
    i_scl_host.wr(lo, 8'h61, pq);
    setup(lo, 8'hc6);
    rdCmp(8'h61, pq);
    setup(lo, 8'hc2);
    rdCmp(8'h61, dq);
    rdCmp(8'h60, {8'hc2});
    runCheck(VCODE, 8'h18);
    pq[0] = pq[0] ^ 8'h01;
    setup(lo, 8'hc4);
    i_scl_host.wr(lo, 8'h61, {pq[0]});
    runCheck(8'hff, 8'h10);
    pq[0] = pq[0] ^ 8'h01;
    setup(lo, 8'hc4);
    i_scl_host.wr(lo, 8'h61, {pq[0]});
    runCheck(VCODE, 8'h18);
    report_and_stop();
  end
endmodule
